// *** hw/psp_top.sv ***
// Pattern sync pulse generator: APB registers, range checks, sequence mode and gating output
// Notes on behaviour
// - Sequence mode selects continuous repeat or burst transmission of the pattern.
// - Burst allowed only for pseudo-random, zero-run, user data and mixed patterns.
// - Repeat mode sends pattern and data continuously without gaps.
// - In repeat mode the sync pulse stays high for the programmed width in bits.
// - Width is a multiple of eight bits on a single channel.
// - Pulse rises delay bits after the first pattern bit; delay multiple of eight.
// - Single channel: 128 to LCM(length,128)-128, step 8, cap 34 359 738 240.
// - Merged channels: 256 to LCM(length,256)-256, step 16, cap 68 719 476 480.
// - Mixed single channel: 128 to rows times length times blocks minus 128, cap given.
// - Mixed merged: 256 to frame size minus 256, step 16.
// - Single channel: lengths up to 511 are repeated to reach at least 512.
// - Merged: lengths up to 1023 are repeated to reach at least 1024.
// - Delay counts from pattern start to the pulse rising edge.
// - Pattern length comes from the first data channel; settings shared by both outputs.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"
module psp_top
  import psp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Pattern and gating output
  output logic             sync_pulse,
  output logic             pattern_start,
  output logic             pattern_continuous,
  output logic             burst_active
);
  psp_cfg_if cfg ();

  logic [5:0]  ctrl_reg, ctrl_next;
  logic [31:0] len_reg, len_next;
  logic [31:0] geom_reg, geom_next;
  logic [39:0] dly_reg, dly_next;
  logic [39:0] wid_reg, wid_next;
  logic        recalc_reg, recalc_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        err_reg, err_next;

  logic        wr;
  logic        rd;
  logic        hit;
  psp_pat_t    pat;
  logic        merge;
  logic        burst_ok;
  logic        eff_burst;
  logic        refused;
  logic [39:0] min_v;
  logic [39:0] mask_v;
  logic [39:0] cap_v;
  logic        dly_ok;
  logic        wid_ok;
  logic        valid;
  logic [31:0] stat;

  assign pat   = psp_pat_t'(ctrl_reg[`PSP_CTRL_TYPE_HI:`PSP_CTRL_TYPE_LO]);
  assign merge = ctrl_reg[`PSP_CTRL_MERGE];

  // Sequence mode; an unsupported burst request falls back to repeat
  always_comb begin
    burst_ok  = (pat == PSP_PAT_PRBS) || (pat == PSP_PAT_DATA) ||
                (pat == PSP_PAT_ZERO) || (pat == PSP_PAT_MIXED);
    eff_burst = ctrl_reg[`PSP_CTRL_BURST] && burst_ok;
    refused   = ctrl_reg[`PSP_CTRL_BURST] && !burst_ok;
  end

  // Range checks for delay and width against the derived period
  function automatic logic in_range(input logic [39:0] v, input logic [39:0] mn, input logic [39:0] mk,
                                    input logic [39:0] cp, input logic [39:0] per);
    return ((v & mk) == 40'h0) && (v >= mn) && (per >= mn + mn) && (v <= per - mn) && (v <= cp);
  endfunction

  always_comb begin
    min_v  = merge ? `PSP_MIN_2CH : `PSP_MIN_1CH;
    mask_v = merge ? `PSP_MASK_2CH : `PSP_MASK_1CH;
    if (pat == PSP_PAT_MIXED) begin
      cap_v = merge ? `PSP_CAP_NONE : `PSP_CAP_MIX_1CH;
    end else begin
      cap_v = merge ? `PSP_CAP_2CH : `PSP_CAP_1CH;
    end
    dly_ok = in_range(dly_reg, min_v, mask_v, cap_v, cfg.period);
    wid_ok = in_range(wid_reg, min_v, mask_v, cap_v, cfg.period);
    valid  = dly_ok && wid_ok && !cfg.busy;
  end

  // Pulse runs only in repeat mode with gating on and settings in range
  assign cfg.pat_len = len_reg;
  assign cfg.merge   = merge;
  assign cfg.mixed   = (pat == PSP_PAT_MIXED);
  assign cfg.row_len = geom_reg[`PSP_GEOM_ROW_HI:`PSP_GEOM_ROW_LO];
  assign cfg.rows    = geom_reg[`PSP_GEOM_NR_HI:`PSP_GEOM_NR_LO];
  assign cfg.blocks  = geom_reg[`PSP_GEOM_BLK_HI:`PSP_GEOM_BLK_LO];
  assign cfg.recalc  = recalc_reg;
  assign cfg.delay   = dly_reg;
  assign cfg.width   = wid_reg;
  assign cfg.run     = ctrl_reg[`PSP_CTRL_GATE] && !eff_burst && valid;

  psp_period_calc u_calc (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .cfg     (cfg.calc_mp)
  );

  psp_pulse_gen u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .cfg     (cfg.gen_mp)
  );

  assign sync_pulse         = cfg.pulse;
  assign pattern_start      = cfg.start;
  assign pattern_continuous = !eff_burst;
  assign burst_active       = eff_burst;

  // APB: zero wait states while enabled; a frozen block stretches the access
  assign pready  = ce;
  assign wr      = psel && penable && pwrite && ce;
  assign rd      = psel && !penable && !pwrite && ce;

  always_comb begin
    stat = 32'h0;
    stat[`PSP_STAT_VALID]   = valid;
    stat[`PSP_STAT_REFUSED] = refused;
    stat[`PSP_STAT_PULSE]   = cfg.pulse;
    stat[`PSP_STAT_BUSY]    = cfg.busy;
  end

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      `PSP_OFF_CTRL:   rdata_next = {26'h0, ctrl_reg};
      `PSP_OFF_LEN:    rdata_next = len_reg;
      `PSP_OFF_GEOM:   rdata_next = geom_reg;
      `PSP_OFF_DLY_LO: rdata_next = dly_reg[31:0];
      `PSP_OFF_DLY_HI: rdata_next = {24'h0, dly_reg[39:32]};
      `PSP_OFF_WID_LO: rdata_next = wid_reg[31:0];
      `PSP_OFF_WID_HI: rdata_next = {24'h0, wid_reg[39:32]};
      `PSP_OFF_STAT:   rdata_next = stat;
      `PSP_OFF_PER_LO: rdata_next = cfg.period[31:0];
      `PSP_OFF_PER_HI: rdata_next = {24'h0, cfg.period[39:32]};
      default: begin
        rdata_next = 32'h0;
        hit        = 1'b0;
      end
    endcase
    if (!rd) begin
      rdata_next = rdata_reg;
    end
    err_next    = (psel && !penable && ce) ? !hit : err_reg;
    ctrl_next   = ctrl_reg;
    len_next    = len_reg;
    geom_next   = geom_reg;
    dly_next    = dly_reg;
    wid_next    = wid_reg;
    recalc_next = 1'b0;
    if (wr) begin
      unique case (paddr)
        `PSP_OFF_CTRL: begin
          ctrl_next   = pwdata[5:0];
          recalc_next = 1'b1;
        end
        `PSP_OFF_LEN: begin
          len_next    = pwdata;
          recalc_next = 1'b1;
        end
        `PSP_OFF_GEOM: begin
          geom_next   = pwdata;
          recalc_next = 1'b1;
        end
        `PSP_OFF_DLY_LO: dly_next = {dly_reg[39:32], pwdata};
        `PSP_OFF_DLY_HI: dly_next = {pwdata[7:0], dly_reg[31:0]};
        `PSP_OFF_WID_LO: wid_next = {wid_reg[39:32], pwdata};
        `PSP_OFF_WID_HI: wid_next = {pwdata[7:0], wid_reg[31:0]};
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `PSP_CTRL_RST;
      len_reg    <= `PSP_LEN_RST;
      geom_reg   <= `PSP_GEOM_RST;
      dly_reg    <= `PSP_DW_RST;
      wid_reg    <= `PSP_DW_RST;
      recalc_reg <= 1'b1;
      rdata_reg  <= 32'h0;
      err_reg    <= 1'b0;
    end else if (ce) begin
      ctrl_reg   <= ctrl_next;
      len_reg    <= len_next;
      geom_reg   <= geom_next;
      dly_reg    <= dly_next;
      wid_reg    <= wid_next;
      recalc_reg <= recalc_next;
      rdata_reg  <= rdata_next;
      err_reg    <= err_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pslverr = err_reg && psel && penable;

  AST_BURST_REFUSED: assert property (@(posedge pclk) disable iff (!presetn)
    refused |-> !burst_active && pattern_continuous) else $error("burst taken for unsupported pattern");
  AST_CONT: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[`PSP_CTRL_BURST] |-> pattern_continuous) else $error("repeat mode not continuous");
  AST_STEP: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.run |-> (dly_reg[2:0] == 3'h0) && (wid_reg[2:0] == 3'h0) && (!merge || !dly_reg[3] && !wid_reg[3]))
    else $error("pulse running with off-step setting");
  AST_MIN: assert property (@(posedge pclk) disable iff (!presetn)
    cfg.run |-> wid_reg >= min_v && dly_reg <= cfg.period - min_v) else $error("pulse running out of range");
  AST_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_reg[`PSP_CTRL_GATE] ##1 !ctrl_reg[`PSP_CTRL_GATE] |-> !sync_pulse) else $error("pulse with gating off");
endmodule
`default_nettype wire

// *** hw/psp_regs.svh ***
// Register offsets, fields, reset values and range limits of the sync pulse generator
`ifndef PSP_REGS_SVH
`define PSP_REGS_SVH
`define PSP_OFF_CTRL     12'h000
`define PSP_OFF_LEN      12'h004
`define PSP_OFF_GEOM     12'h008
`define PSP_OFF_DLY_LO   12'h00c
`define PSP_OFF_DLY_HI   12'h010
`define PSP_OFF_WID_LO   12'h014
`define PSP_OFF_WID_HI   12'h018
`define PSP_OFF_STAT     12'h01c
`define PSP_OFF_PER_LO   12'h020
`define PSP_OFF_PER_HI   12'h024
`define PSP_CTRL_BURST   0
`define PSP_CTRL_TYPE_LO 1
`define PSP_CTRL_TYPE_HI 3
`define PSP_CTRL_MERGE   4
`define PSP_CTRL_GATE    5
`define PSP_GEOM_ROW_LO  0
`define PSP_GEOM_ROW_HI  15
`define PSP_GEOM_NR_LO   16
`define PSP_GEOM_NR_HI   23
`define PSP_GEOM_BLK_LO  24
`define PSP_GEOM_BLK_HI  31
`define PSP_STAT_VALID   0
`define PSP_STAT_REFUSED 1
`define PSP_STAT_PULSE   2
`define PSP_STAT_BUSY    3
`define PSP_CTRL_RST     6'h00
`define PSP_LEN_RST      32'h0000_007f
`define PSP_GEOM_RST     32'h0000_0000
`define PSP_DW_RST       40'h00_0000_0080
`define PSP_MIN_1CH      40'h00_0000_0080
`define PSP_MIN_2CH      40'h00_0000_0100
`define PSP_MASK_1CH     40'h00_0000_0007
`define PSP_MASK_2CH     40'h00_0000_000f
`define PSP_CAP_1CH      40'h07_ffff_ff80
`define PSP_CAP_2CH      40'h0f_ffff_ff00
`define PSP_CAP_MIX_1CH  40'h00_8fff_ff80
`define PSP_CAP_NONE     40'hff_ffff_ffff
`define PSP_THR_1CH      40'h00_0000_0200
`define PSP_THR_2CH      40'h00_0000_0400
`define PSP_EXP_1CH      4'h7
`define PSP_EXP_2CH      4'h8
`endif

// *** hw/psp_pkg.sv ***
// Types shared by the sync pulse generator modules
package psp_pkg;
  typedef enum logic [2:0] {
    PSP_PAT_PRBS  = 3'h0,
    PSP_PAT_DATA  = 3'h1,
    PSP_PAT_ZERO  = 3'h2,
    PSP_PAT_MIXED = 3'h3,
    PSP_PAT_OTHER = 3'h4
  } psp_pat_t;
  typedef enum logic [1:0] {
    PSP_IDLE  = 2'b00,
    PSP_ACC   = 2'b01,
    PSP_SHIFT = 2'b11
  } psp_calc_state_t;
endpackage

// *** hw/psp_cfg_if.sv ***
// Internal carrier between register file, period calculator and pulse generator
`timescale 1ns/1ps
`default_nettype none
interface psp_cfg_if;
  logic [31:0] pat_len;
  logic        merge;
  logic        mixed;
  logic [15:0] row_len;
  logic [7:0]  rows;
  logic [7:0]  blocks;
  logic        recalc;
  logic [39:0] period;
  logic        busy;
  logic [39:0] delay;
  logic [39:0] width;
  logic        run;
  logic        pulse;
  logic        start;
  modport top_mp  (output pat_len, merge, mixed, row_len, rows, blocks, recalc, delay, width, run,
                   input period, busy, pulse, start);
  modport calc_mp (input pat_len, merge, mixed, row_len, rows, blocks, recalc, output period, busy);
  modport gen_mp  (input period, delay, width, run, output pulse, start);
endinterface
`default_nettype wire

// *** hw/psp_period_calc.sv ***
// Pulse period calculator: stretched pattern length, LCM with the step base, or mixed frame size
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"
module psp_period_calc
  import psp_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Configuration and result
  psp_cfg_if.calc_mp cfg
);
  psp_calc_state_t state_reg, state_next;
  logic [39:0]     acc_reg, acc_next;
  logic [39:0]     per_reg, per_next;
  logic [39:0]     thr;
  logic [3:0]      lcm_exp;
  logic [3:0]      tz;

  // Trailing zeros, saturated at the exponent of the step base
  function automatic logic [3:0] tzc(input logic [39:0] v, input logic [3:0] lim);
    logic [3:0] n;
    logic       stop;
    n = 4'h0;
    stop = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (!stop && !v[i] && n < lim) begin
        n = n + 4'h1;
      end else begin
        stop = 1'b1;
      end
    end
    return n;
  endfunction

  always_comb begin
    thr        = cfg.merge ? `PSP_THR_2CH : `PSP_THR_1CH;
    lcm_exp    = cfg.merge ? `PSP_EXP_2CH : `PSP_EXP_1CH;
    tz         = tzc(acc_reg, lcm_exp);
    state_next = state_reg;
    acc_next   = acc_reg;
    per_next   = per_reg;
    if (cfg.recalc) begin
      acc_next = {8'h00, cfg.pat_len};
      if (cfg.mixed) begin
        per_next   = 40'(cfg.row_len) * 40'(cfg.rows) * 40'(cfg.blocks);
        state_next = PSP_IDLE;
      end else begin
        per_next   = 40'h0;
        state_next = (cfg.pat_len == 32'h0) ? PSP_IDLE : PSP_ACC;
      end
    end else begin
      unique case (state_reg)
        PSP_IDLE: begin
        end
        PSP_ACC: begin
          // Short patterns are repeated whole until they reach the threshold
          if (acc_reg < thr) begin
            acc_next = acc_reg + {8'h00, cfg.pat_len};
          end else begin
            state_next = PSP_SHIFT;
          end
        end
        PSP_SHIFT: begin
          // LCM with a power of two is a shift by the missing zero bits
          per_next   = acc_reg << (lcm_exp - tz);
          state_next = PSP_IDLE;
        end
        default: begin
          state_next = PSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PSP_IDLE;
      acc_reg   <= 40'h0;
      per_reg   <= 40'h0;
    end else if (ce) begin
      state_reg <= state_next;
      acc_reg   <= acc_next;
      per_reg   <= per_next;
    end
  end

  assign cfg.period = per_reg;
  assign cfg.busy   = (state_reg != PSP_IDLE) || cfg.recalc;
endmodule
`default_nettype wire

// *** hw/psp_pulse_gen.sv ***
// Bit position counter and sync pulse window
`timescale 1ns/1ps
`default_nettype none
module psp_pulse_gen
  import psp_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Timing settings and pulse
  psp_cfg_if.gen_mp cfg
);
  logic [39:0] pos_reg, pos_next;
  logic        pulse_reg, pulse_next;
  logic [39:0] off;
  logic [39:0] hi_cnt;

  always_comb begin
    pos_next   = 40'h0;
    pulse_next = 1'b0;
    off        = 40'h0;
    if (cfg.run) begin
      pos_next   = (pos_reg >= cfg.period - 40'h1) ? 40'h0 : pos_reg + 40'h1;
      // Window judged for the coming position, so the registered pulse rises on the delay bit itself;
      // the offset is taken modulo the period so a late window wraps into the next one
      off        = (pos_next >= cfg.delay) ? pos_next - cfg.delay
                                           : pos_next + cfg.period - cfg.delay;
      pulse_next = off < cfg.width;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg   <= 40'h0;
      pulse_reg <= 1'b0;
    end else if (ce) begin
      pos_reg   <= pos_next;
      pulse_reg <= pulse_next;
    end
  end

  assign cfg.pulse = pulse_reg;
  assign cfg.start = cfg.run && (pos_reg == 40'h0);

  // High-time counter read only by the width check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt <= 40'h0;
    end else if (ce) begin
      hi_cnt <= pulse_reg ? hi_cnt + 40'h1 : 40'h0;
    end
  end

  AST_OFF_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !cfg.run |=> !cfg.pulse) else $error("pulse high while stopped");
  AST_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.run && pos_reg == cfg.period - 40'h1 |=> pos_reg == 40'h0 || !ce)
    else $error("position did not wrap at period end");
  AST_RISE_AT_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    ce && cfg.run && pos_next == cfg.delay && cfg.width != 40'h0 |=> cfg.pulse && pos_reg == cfg.delay)
    else $error("pulse not high at delay position");
  AST_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
    $past(cfg.run) && cfg.run && $stable(cfg.width) && cfg.width < cfg.period |-> hi_cnt <= cfg.width)
    else $error("pulse longer than programmed width");
endmodule
`default_nettype wire

// *** verification/psp_sink_model.sv ***
// Far-side equipment model: measures sync pulse position, width and pattern period
`timescale 1ns/1ps
`default_nettype none
module psp_sink_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Signals from the generator
  input  wire logic        sync_pulse,
  input  wire logic        pattern_start,
  // Measured figures
  output logic      [39:0] hi_len,
  output logic      [39:0] rise_at,
  output logic      [39:0] per,
  output logic      [31:0] pulses
);
  logic [39:0] pos;
  logic [39:0] run;
  logic        prev;

  // Position mirrors the generator's bit counter: the period length in the start cycle, 1 in the cycle after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos     <= 40'h0;
      run     <= 40'h0;
      prev    <= 1'b0;
      hi_len  <= 40'h0;
      rise_at <= 40'h0;
      per     <= 40'h0;
      pulses  <= 32'h0;
    end else begin
      prev <= sync_pulse;
      pos  <= pattern_start ? 40'h1 : pos + 40'h1;
      run  <= sync_pulse ? run + 40'h1 : 40'h0;
      if (pattern_start) begin
        per <= pos;
      end
      if (sync_pulse && !prev) begin
        rise_at <= pos;
      end
      // A pulse counts only once it has ended, so a cut-off pulse is still seen
      if (!sync_pulse && prev) begin
        hi_len <= run;
        pulses <= pulses + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/psp_top_tb.sv ***
// Self-checking bench for the sync pulse generator
`timescale 1ns/1ps
`default_nettype none
`include "psp_regs.svh"
module psp_top_tb;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        ce      = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sync_pulse;
  logic        pattern_start;
  logic        pattern_continuous;
  logic        burst_active;
  logic [39:0] hi_len;
  logic [39:0] rise_at;
  logic [39:0] per;
  logic [31:0] pulses;
  logic [31:0] rd;
  logic        er;
  int          err_total   = 0;
  int          comparisons = 0;

  always #5 pclk = ~pclk;

  psp_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_pulse(sync_pulse), .pattern_start(pattern_start), .pattern_continuous(pattern_continuous),
    .burst_active(burst_active));

  psp_sink_model sink (.pclk(pclk), .presetn(presetn), .sync_pulse(sync_pulse),
    .pattern_start(pattern_start), .hi_len(hi_len), .rise_at(rise_at), .per(per), .pulses(pulses));

  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_total++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls the busy flag; a recalc that never ends counts as a mismatch
  task automatic settle();
    int n;
    for (n = 0; n < 100; n++) begin
      apb(1'b0, `PSP_OFF_STAT, 32'h0);
      if (rd[`PSP_STAT_BUSY] === 1'b0) break;
    end
    if (n == 100) begin
      err_total++;
      test_done();
    end
  endtask

  task automatic setup(input logic [31:0] ctrl, len, geom, dly, wid);
    apb(1'b1, `PSP_OFF_LEN, len);
    apb(1'b1, `PSP_OFF_GEOM, geom);
    apb(1'b1, `PSP_OFF_DLY_LO, dly);
    apb(1'b1, `PSP_OFF_WID_LO, wid);
    apb(1'b1, `PSP_OFF_CTRL, ctrl);
    settle();
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Stale measurements from before the change are flushed by three periods
  task automatic meas(input int period, input int dly, input int wid);
    repeat (3 * period + 20) @(posedge pclk);
    chk(per, period);
    chk(rise_at, dly);
    chk(hi_len, wid);
  endtask

  task automatic quiet();
    logic [31:0] p0;
    p0 = pulses;
    repeat (700) @(posedge pclk);
    chk(pulses, p0);
    chk(sync_pulse, 1'b0);
  endtask

  task automatic t_reset();
    chk(sync_pulse, 1'b0);
    chk(pattern_continuous, 1'b1);
    chk(burst_active, 1'b0);
    settle();
    rchk(`PSP_OFF_CTRL, 32'h0);
    rchk(`PSP_OFF_LEN, 32'h0000_007f);
    rchk(`PSP_OFF_GEOM, 32'h0);
    rchk(`PSP_OFF_DLY_LO, 32'h0000_0080);
    rchk(`PSP_OFF_WID_LO, 32'h0000_0080);
    rchk(`PSP_OFF_PER_LO, 32'h0001_3d80);
    rchk(`PSP_OFF_PER_HI, 32'h0);
  endtask

  task automatic t_bus();
    apb(1'b0, 12'h030, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h030, 32'h1234_5678);
    chk(er, 1'b1);
    // Upper halves: only the low byte is kept, and a 33-bit setting is past the period
    apb(1'b1, `PSP_OFF_DLY_HI, 32'h0000_0301);
    rchk(`PSP_OFF_DLY_HI, 32'h0000_0001);
    rchk(`PSP_OFF_STAT, 32'h0);
    apb(1'b1, `PSP_OFF_DLY_HI, 32'h0);
    apb(1'b1, `PSP_OFF_WID_HI, 32'h0000_0002);
    rchk(`PSP_OFF_WID_HI, 32'h0000_0002);
    rchk(`PSP_OFF_STAT, 32'h0);
    apb(1'b1, `PSP_OFF_WID_HI, 32'h0);
    rchk(`PSP_OFF_STAT, 32'h0000_0001);
    apb(1'b1, `PSP_OFF_PER_LO, 32'h0);
    chk(er, 1'b0);
    rchk(`PSP_OFF_PER_LO, 32'h0001_3d80);
    @(posedge pclk);
    ce <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(pready, 1'b0);
    ce <= 1'b1;
  endtask

  task automatic t_repeat();
    setup(32'h20, 32'd640, 32'h0, 32'd256, 32'd136);
    rchk(`PSP_OFF_STAT, 32'h0000_0001);
    meas(640, 256, 136);
    chk(pattern_continuous, 1'b1);
    setup(32'h20, 32'd640, 32'h0, 32'd512, 32'd128);
    meas(640, 512, 128);
  endtask

  task automatic t_invalid();
    logic [31:0] tbl [5][2];
    tbl = '{'{32'd256, 32'd132}, '{32'd252, 32'd128}, '{32'd120, 32'd128},
            '{32'd520, 32'd128}, '{32'd256, 32'd520}};
    for (int i = 0; i < 5; i++) begin
      setup(32'h20, 32'd640, 32'h0, tbl[i][0], tbl[i][1]);
      rchk(`PSP_OFF_STAT, 32'h0);
      quiet();
    end
  endtask

  task automatic t_merge();
    setup(32'h30, 32'd640, 32'h0, 32'd256, 32'd272);
    rchk(`PSP_OFF_PER_LO, 32'd1280);
    meas(1280, 256, 272);
    setup(32'h30, 32'd640, 32'h0, 32'd264, 32'd272);
    rchk(`PSP_OFF_STAT, 32'h0);
  endtask

  task automatic t_mixed();
    setup(32'h26, 32'd640, 32'h0204_0028, 32'd128, 32'd128);
    rchk(`PSP_OFF_PER_LO, 32'd320);
    meas(320, 128, 128);
    setup(32'h36, 32'd640, 32'h0204_0050, 32'd256, 32'd256);
    rchk(`PSP_OFF_PER_LO, 32'd640);
    meas(640, 256, 256);
  endtask

  task automatic t_burst();
    for (int t = 0; t < 5; t++) begin
      setup(32'h21 | (t << 1), 32'd640, 32'h0204_0028, 32'd128, 32'd128);
      chk(burst_active, t < 4);
      chk(pattern_continuous, t >= 4);
      apb(1'b0, `PSP_OFF_STAT, 32'h0);
      chk(rd[`PSP_STAT_REFUSED], t >= 4);
      if (t == 0) quiet();
    end
  endtask

  task automatic t_gate();
    setup(32'h00, 32'd640, 32'h0, 32'd256, 32'd136);
    rchk(`PSP_OFF_STAT, 32'h0000_0001);
    quiet();
  endtask

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_bus();
    t_repeat();
    t_invalid();
    t_merge();
    t_mixed();
    t_burst();
    t_gate();
    test_done();
  end
endmodule
`default_nettype wire
